// [rtl/tfe_pkg.sv]
// Operation
// R1 - Bytes are eight bits, most significant bit first, both directions.
// R2 - Pointer resets to zero, selecting the capability register.
// R3 - Pointer holds its last value; select bits decide read-only or read/write.
// R4 - Master writes address, pointer, then exactly two data bytes for a register.
// R5 - Read with current pointer: read address byte, device returns two bytes.
// R6 - Other register: write address, pointer, repeated start, read address.
// R7 - Read end accepts ack or nack; nack marks the final byte.
// R8 - After a read ends a new measurement may take up to 125 ms.
// R9 - Master clock at least 10 kHz; thermal bus timeout at most 50 ms.
// R10 - Start is data falling with clock high; ignore the bus until one.
// R11 - Master ends each operation with stop; device detects it.
// R12 - Receiver of a good byte pulls data low in the ack clock.
// R13 - Seven-bit address: four type bits then three select pin bits.
// R14 - Select pins are sampled at the start of every access.
// R15 - Type 0011 thermal, 1010 memory array, 0110 protection.
// R16 - Last address bit: 1 read, 0 write.
// R17 - Protection select 001 write sets, 011 clears reversible; read reports.
// R18 - Protection with pin select write sets permanent; read reports it.
// R19 - Unconnected select pins count as zero.
// R20 - Reset: monitoring on, alert released, limits zero, capability 000f, comparator.
// R21 - Thermal function waits at least 250 ms before valid measurement.
// R22 - A start aborts any transfer and resets the bus logic.
// R23 - Pointer is eight bits; only low three select, upper five zero.
// R24 - Thermal data registers are sixteen bits, moved as two bytes.
// R25 - Unmatched address byte is not acknowledged; data line stays released.
// R26 - Two-byte transfers carry the high byte first.
package tfe_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned TIMEOUT_MS = 50;
   localparam int unsigned TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;
   localparam int unsigned WARMUP_MS = 250;
   localparam int unsigned WARMUP_CYC = CLK_HZ / 1000 * WARMUP_MS;
   localparam int unsigned CNT_W = 24;
   localparam logic [3:0] TYPE_THERMAL = 4'h3;
   localparam logic [3:0] TYPE_MEMORY = 4'ha;
   localparam logic [3:0] TYPE_PROTECT = 4'h6;
   localparam logic [2:0] SEL_SET_REV = 3'h1;
   localparam logic [2:0] SEL_CLR_REV = 3'h3;
   localparam logic [2:0] PTR_RESET = 3'h0;
   localparam logic [2:0] PTR_CAP = 3'h0;
   localparam logic [2:0] PTR_CONF = 3'h1;
   localparam logic [2:0] PTR_UPPER = 3'h2;
   localparam logic [2:0] PTR_LOWER = 3'h3;
   localparam logic [2:0] PTR_CRIT = 3'h4;
   localparam logic [2:0] PTR_TEMP = 3'h5;
   localparam logic [2:0] PTR_MFR = 3'h6;
   localparam logic [15:0] CAP_VALUE = 16'h000f;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [3:0] BIT_LAST = 4'h8;
   localparam logic [3:0] TX_LAST = 4'h7;
   localparam logic [1:0] IDX_DATA_LO = 2'h2;
   localparam logic [1:0] IDX_MAX = 2'h3;
   localparam logic [7:0] PROT_FILL = 8'hff;
   localparam int unsigned FIFO_WIDTH = 20;
   localparam int unsigned FIFO_DEPTH = 8;
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} tfe_state_t;
   typedef enum logic [1:0] {FN_THERMAL, FN_MEMORY, FN_PROT_REV, FN_PROT_PERM} tfe_func_t;
endpackage

// [rtl/tfe_fifo_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface tfe_fifo_if #(parameter int unsigned W = 8);
   logic [W-1:0] in_data;
   logic in_valid;
   logic in_ready;
   logic [W-1:0] out_data;
   logic out_valid;
   logic out_ready;
   modport fifo (input in_data, input in_valid, input out_ready, output in_ready, output out_data, output out_valid);
   modport client (output in_data, output in_valid, output out_ready, input in_ready, input out_data, input out_valid);
endinterface
`default_nettype wire

// [rtl/tfe_fifo.sv]
`timescale 1ns/100ps
`default_nettype none
module tfe_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   tfe_fifo_if.fifo q
);
   localparam int unsigned AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr_r;
   logic [AW-1:0] rptr_r;
   logic [AW:0] cnt_r;
   logic [WIDTH-1:0] out_data_r;
   logic out_valid_r;
   logic push;
   logic pop;
   ////////////////////////////////////////////////////////////////
   assign q.in_ready = (cnt_r != DEPTH_C);
   assign push = q.in_valid && q.in_ready;
   assign pop = (cnt_r != '0) && (!out_valid_r || q.out_ready);
   assign q.out_data = out_data_r;
   assign q.out_valid = out_valid_r;
   ////////////////////////////////////////////////////////////////
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wptr_r] <= q.in_data;
      end
   end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wptr_r <= (wptr_r == LAST_C) ? '0 : wptr_r + 1'b1;
         end
         if (pop)
         begin
            rptr_r <= (rptr_r == LAST_C) ? '0 : rptr_r + 1'b1;
         end
         if (push && !pop)
         begin
            cnt_r <= cnt_r + 1'b1;
         end
         else if (pop && !push)
         begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
   // registered output stage
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         out_valid_r <= 1'b0;
         out_data_r <= '0;
      end
      else if (pop)
      begin
         out_valid_r <= 1'b1;
         out_data_r <= mem[rptr_r];
      end
      else if (q.out_ready)
      begin
         out_valid_r <= 1'b0;
      end
   end
endmodule // tfe_fifo
`default_nettype wire

// [rtl/tfe_target.sv]
`timescale 1ns/100ps
`default_nettype none
module tfe_target #(
   parameter int unsigned TIMEOUT_CYCLES = tfe_pkg::TIMEOUT_CYC,
   parameter int unsigned WARMUP_CYCLES = tfe_pkg::WARMUP_CYC,
   // arbitrary identification values
   parameter logic [15:0] MFR_ID = 16'h0a5a,
   parameter logic [15:0] DEV_ID = 16'h0101
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   input wire logic [2:0] ADDR_SEL,
   input wire logic [15:0] TEMP_DATA,
   input wire logic [7:0] MEM_RD_DATA,
   output logic WR_VALID,
   input wire logic WR_READY,
   output logic [tfe_pkg::FIFO_WIDTH-1:0] WR_DATA,
   output logic [2:0] PTR_SEL,
   output logic [15:0] CONF_WORD,
   output logic [15:0] UPPER_LIMIT,
   output logic [15:0] LOWER_LIMIT,
   output logic [15:0] CRIT_LIMIT,
   output logic WP_REVERSIBLE,
   output logic WP_PERMANENT,
   output logic EVENT_OE,
   output logic SENSOR_READY,
   output logic MEAS_REQ
);
   import tfe_pkg::*;
   localparam logic [CNT_W-1:0] TMO_LAST = CNT_W'(TIMEOUT_CYCLES - 1);
   localparam logic [CNT_W-1:0] WARM_LAST = CNT_W'(WARMUP_CYCLES - 1);

   tfe_state_t state_r;
   tfe_func_t func_r;
   tfe_func_t addr_func;
   logic scl_q_r;
   logic sda_q_r;
   logic [3:0] cnt_r;
   logic [7:0] sh_r;
   logic [7:0] tx_r;
   logic [1:0] idx_r;
   logic rw_r;
   logic ack_r;
   logic [2:0] sel_r;
   logic [2:0] ptr_r;
   logic [7:0] hi_r;
   logic [15:0] conf_r;
   logic [15:0] upper_r;
   logic [15:0] lower_r;
   logic [15:0] crit_r;
   logic wp_rev_r;
   logic wp_perm_r;
   logic sda_oe_r;
   logic sda_out_r;
   logic event_oe_r;
   logic meas_r;
   logic ready_r;
   logic [CNT_W-1:0] tmo_cnt_r;
   logic [CNT_W-1:0] warm_cnt_r;
   logic start_det;
   logic stop_det;
   logic scl_rise;
   logic scl_fall;
   logic tmo_hit;
   logic addr_done;
   logic addr_ack;
   logic addr_take;
   logic rx_done;
   logic rx_ack;
   logic writable;
   logic push;
   logic tx_lsb;
   logic [15:0] word;
   logic [7:0] next_tx;

   tfe_fifo_if #(.W(FIFO_WIDTH)) fq ();

   tfe_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(CLK),
      .rst(RST),
      .q(fq.fifo)
   );

   ////////////////////////////////////////////////////////////////
   // bus edge and condition detect
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end
      else
      begin
         scl_q_r <= SCL_IN;
         sda_q_r <= SDA_IN;
      end
   end

   assign start_det = SCL_IN && scl_q_r && sda_q_r && !SDA_IN; // R10
   assign stop_det = SCL_IN && scl_q_r && !sda_q_r && SDA_IN; // R11
   assign scl_rise = SCL_IN && !scl_q_r;
   assign scl_fall = !SCL_IN && scl_q_r;

   ////////////////////////////////////////////////////////////////
   // address decode
   assign addr_done = (state_r == ST_ADDR) && scl_fall && (cnt_r == BIT_LAST);

   always_comb
   begin
      addr_ack = 1'b0;
      addr_func = FN_THERMAL;
      if (sh_r[7:4] == TYPE_THERMAL && sh_r[3:1] == sel_r) // R13 R15
      begin
         addr_ack = 1'b1;
      end
      else if (sh_r[7:4] == TYPE_MEMORY && sh_r[3:1] == sel_r) // R15
      begin
         addr_ack = 1'b1;
         addr_func = FN_MEMORY;
      end
      else if (sh_r[7:4] == TYPE_PROTECT && (sh_r[3:1] == SEL_SET_REV || sh_r[3:1] == SEL_CLR_REV))
      begin
         // read reports state by ack; write refused once permanent
         addr_ack = sh_r[0] ? !wp_rev_r : !wp_perm_r; // R17
         addr_func = FN_PROT_REV;
      end
      else if (sh_r[7:4] == TYPE_PROTECT && sh_r[3:1] == sel_r)
      begin
         addr_ack = !wp_perm_r; // R18
         addr_func = FN_PROT_PERM;
      end
   end

   assign addr_take = addr_done && addr_ack;

   ////////////////////////////////////////////////////////////////
   // received byte handling
   assign rx_done = (state_r == ST_RX) && scl_fall && (cnt_r == BIT_LAST);
   assign writable = (ptr_r >= PTR_CONF) && (ptr_r <= PTR_CRIT); // R3

   always_comb
   begin
      rx_ack = 1'b0;
      push = 1'b0;
      unique case (func_r)
         FN_THERMAL:
         begin
            if (idx_r == IDX_DATA_LO)
            begin
               rx_ack = writable && fq.in_ready; // R4
               push = rx_ack;
            end
            else
            begin
               rx_ack = (idx_r != IDX_MAX); // R4
            end
         end
         FN_MEMORY:
         begin
            rx_ack = fq.in_ready;
            push = fq.in_ready;
         end
         FN_PROT_REV, FN_PROT_PERM:
         begin
            rx_ack = 1'b0;
         end
      endcase
   end

   assign fq.in_valid = rx_done && push;
   assign fq.in_data = (func_r == FN_THERMAL) ? {1'b0, ptr_r, hi_r, sh_r} : {1'b1, 3'h0, 8'h00, sh_r}; // R26
   assign fq.out_ready = WR_READY;
   assign WR_VALID = fq.out_valid;
   assign WR_DATA = fq.out_data;

   ////////////////////////////////////////////////////////////////
   // transmit byte select
   always_comb
   begin
      unique case (ptr_r)
         PTR_CAP: word = CAP_VALUE;
         PTR_CONF: word = conf_r;
         PTR_UPPER: word = upper_r;
         PTR_LOWER: word = lower_r;
         PTR_CRIT: word = crit_r;
         PTR_TEMP: word = TEMP_DATA;
         PTR_MFR: word = MFR_ID;
         default: word = DEV_ID;
      endcase
   end

   assign tx_lsb = (state_r == ST_ADDR_ACK) ? 1'b0 : !idx_r[0];

   always_comb
   begin
      unique case (func_r)
         FN_THERMAL: next_tx = tx_lsb ? word[7:0] : word[15:8]; // R24 R26
         FN_MEMORY: next_tx = MEM_RD_DATA;
         FN_PROT_REV, FN_PROT_PERM: next_tx = PROT_FILL;
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // bus state machine
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         state_r <= ST_IDLE;
         func_r <= FN_THERMAL;
         cnt_r <= '0;
         sh_r <= '0;
         tx_r <= '0;
         idx_r <= '0;
         rw_r <= 1'b0;
         ack_r <= 1'b0;
         sda_oe_r <= 1'b0;
      end
      else if (start_det)
      begin
         state_r <= ST_ADDR; // R22
         cnt_r <= '0;
         sda_oe_r <= 1'b0;
      end
      else if (stop_det || tmo_hit)
      begin
         state_r <= ST_IDLE; // R11 R9
         sda_oe_r <= 1'b0;
      end
      else
      begin
         unique case (state_r)
            ST_IDLE:
            begin
               sda_oe_r <= 1'b0; // R10
            end
            ST_ADDR:
            begin
               if (scl_rise)
               begin
                  sh_r <= {sh_r[6:0], SDA_IN}; // R1
                  cnt_r <= cnt_r + 1'b1;
               end
               else if (addr_done)
               begin
                  if (addr_ack)
                  begin
                     state_r <= ST_ADDR_ACK;
                     sda_oe_r <= 1'b1; // R12
                     func_r <= addr_func;
                     rw_r <= sh_r[0]; // R16
                  end
                  else
                  begin
                     state_r <= ST_IDLE; // R25
                  end
               end
            end
            ST_ADDR_ACK:
            begin
               if (scl_fall)
               begin
                  cnt_r <= '0;
                  idx_r <= '0;
                  if (rw_r)
                  begin
                     state_r <= ST_TX; // R5
                     sda_oe_r <= !next_tx[7]; // R1
                     tx_r <= {next_tx[6:0], 1'b0};
                  end
                  else
                  begin
                     state_r <= ST_RX;
                     sda_oe_r <= 1'b0;
                  end
               end
            end
            ST_RX:
            begin
               if (scl_rise)
               begin
                  sh_r <= {sh_r[6:0], SDA_IN}; // R1
                  cnt_r <= cnt_r + 1'b1;
               end
               else if (rx_done)
               begin
                  state_r <= ST_RX_ACK;
                  sda_oe_r <= rx_ack; // R12
               end
            end
            ST_RX_ACK:
            begin
               if (scl_fall)
               begin
                  state_r <= ST_RX;
                  sda_oe_r <= 1'b0;
                  cnt_r <= '0;
                  idx_r <= (idx_r == IDX_MAX) ? idx_r : idx_r + 1'b1;
               end
            end
            ST_TX:
            begin
               if (scl_fall)
               begin
                  if (cnt_r == TX_LAST)
                  begin
                     state_r <= ST_TX_ACK;
                     sda_oe_r <= 1'b0;
                     cnt_r <= '0;
                  end
                  else
                  begin
                     sda_oe_r <= !tx_r[7]; // R1
                     tx_r <= {tx_r[6:0], 1'b0};
                     cnt_r <= cnt_r + 1'b1;
                  end
               end
            end
            ST_TX_ACK:
            begin
               if (scl_rise)
               begin
                  ack_r <= !SDA_IN;
               end
               else if (scl_fall)
               begin
                  if (ack_r)
                  begin
                     state_r <= ST_TX;
                     idx_r <= (idx_r == IDX_MAX) ? '0 : idx_r + 1'b1;
                     sda_oe_r <= !next_tx[7];
                     tx_r <= {next_tx[6:0], 1'b0};
                  end
                  else
                  begin
                     state_r <= ST_IDLE; // R7
                  end
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // pointer and sample of select pins
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         ptr_r <= PTR_RESET; // R2
         sel_r <= '0;
         hi_r <= '0;
      end
      else
      begin
         if (start_det)
         begin
            sel_r <= ADDR_SEL; // R14 R19
         end
         if (rx_done && func_r == FN_THERMAL && idx_r == '0)
         begin
            ptr_r <= sh_r[2:0]; // R3 R23 R6
         end
         if (rx_done && func_r == FN_THERMAL)
         begin
            hi_r <= sh_r; // R26
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // thermal register shadows
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         conf_r <= REG_RESET; // R20
         upper_r <= REG_RESET;
         lower_r <= REG_RESET;
         crit_r <= REG_RESET;
      end
      else if (rx_done && push && func_r == FN_THERMAL)
      begin
         unique case (ptr_r)
            PTR_CONF: conf_r <= {hi_r, sh_r}; // R24
            PTR_UPPER: upper_r <= {hi_r, sh_r};
            PTR_LOWER: lower_r <= {hi_r, sh_r};
            default: crit_r <= {hi_r, sh_r};
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // write protection
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         wp_rev_r <= 1'b0;
         wp_perm_r <= 1'b0;
      end
      else if (addr_take && !sh_r[0])
      begin
         if (addr_func == FN_PROT_REV)
         begin
            wp_rev_r <= (sh_r[3:1] == SEL_SET_REV); // R17
         end
         if (addr_func == FN_PROT_PERM)
         begin
            wp_perm_r <= 1'b1; // R18
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // timeout, warm-up, measurement request
   assign tmo_hit = (tmo_cnt_r == TMO_LAST);

   always_ff @(posedge CLK)
   begin
      if (RST || SCL_IN || state_r == ST_IDLE || func_r != FN_THERMAL)
      begin
         tmo_cnt_r <= '0;
      end
      else if (!tmo_hit)
      begin
         tmo_cnt_r <= tmo_cnt_r + 1'b1; // R9
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         warm_cnt_r <= '0;
         ready_r <= 1'b0;
      end
      else if (warm_cnt_r == WARM_LAST)
      begin
         ready_r <= 1'b1; // R21
      end
      else
      begin
         warm_cnt_r <= warm_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         meas_r <= 1'b0;
      end
      else
      begin
         meas_r <= (func_r == FN_THERMAL) && rw_r && ((state_r == ST_TX_ACK && scl_fall && !ack_r)
                   || (stop_det && state_r != ST_IDLE)); // R8 R7
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         sda_out_r <= 1'b0;
         event_oe_r <= 1'b0; // R20
      end
      else
      begin
         sda_out_r <= 1'b0;
         event_oe_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   assign SDA_OUT = sda_out_r;
   assign SDA_OE = sda_oe_r;
   assign PTR_SEL = ptr_r;
   assign CONF_WORD = conf_r;
   assign UPPER_LIMIT = upper_r;
   assign LOWER_LIMIT = lower_r;
   assign CRIT_LIMIT = crit_r;
   assign WP_REVERSIBLE = wp_rev_r;
   assign WP_PERMANENT = wp_perm_r;
   assign EVENT_OE = event_oe_r;
   assign SENSOR_READY = ready_r;
   assign MEAS_REQ = meas_r;

   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   a_ptr_reset: assert property ($fell(RST) |-> ptr_r == PTR_RESET) // R2
      else $error("pointer not zero after reset");
   a_sel_sample: assert property (start_det |=> sel_r == $past(ADDR_SEL)) // R14
      else $error("select pins not sampled at start");
   a_nack_bad: assert property (addr_done && !addr_ack |=> !sda_oe_r && state_r == ST_IDLE) // R25
      else $error("unmatched address acknowledged");
   a_ack_good: assert property (addr_done && addr_ack && !start_det |=> sda_oe_r ##0 state_r == ST_ADDR_ACK) // R12
      else $error("matched address not acknowledged");
   a_stop_idle: assert property (stop_det && !start_det |=> state_r == ST_IDLE && !sda_oe_r) // R11
      else $error("stop did not return to idle");
   a_start_abort: assert property (start_det |=> state_r == ST_ADDR && !sda_oe_r) // R22
      else $error("start did not restart the bus logic");
   a_ptr_hold: assert property (!(rx_done && func_r == FN_THERMAL && idx_r == '0) |=> $stable(ptr_r)) // R3
      else $error("pointer changed without a pointer byte");
   a_perm_sticky: assert property (wp_perm_r |=> wp_perm_r) // R18
      else $error("permanent protection cleared");
   a_meas_nack: assert property (state_r == ST_TX_ACK && scl_fall && !ack_r && rw_r && func_r == FN_THERMAL
      && !start_det && !stop_det |=> meas_r) // R8
      else $error("no measurement request after final read byte");
   a_tmo_release: assert property (tmo_hit && !start_det |=> state_r == ST_IDLE) // R9
      else $error("bus timeout did not release");
endmodule // tfe_target
`default_nettype wire

// [testbench/tfe_i2c_master.sv]
`timescale 1ns/100ps
`default_nettype none
module tfe_i2c_master (
   input wire logic clk,
   output logic scl,
   output logic sda,
   input wire logic sda_w
);
   initial
   begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic bit_io(input logic v, output logic s);
      sda <= v;
      tick(2);
      scl <= 1'b1;
      tick(2);
      s = sda_w;
      tick(2);
      scl <= 1'b0;
      tick(2);
   endtask
   task automatic start;
      sda <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(3);
      sda <= 1'b0;
      tick(3);
      scl <= 1'b0;
      tick(2);
   endtask
   task automatic stop;
      sda <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(3);
      sda <= 1'b1;
      tick(3);
   endtask
   task automatic wbyte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(v[i], s);
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   task automatic rbyte(input logic ack, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
      bit_io(~ack, s);
   endtask
endmodule // tfe_i2c_master
`default_nettype wire

// [testbench/tfe_target_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tfe_target_tb_top;
   import tfe_pkg::*;
   localparam int TMO = 200;
   localparam int WARM = 100;
   // arbitrary identification values
   localparam logic [15:0] MID = 16'h3c96;
   localparam logic [15:0] DID = 16'h0702;
   logic CLK, RST, WR_READY, SDA_OUT, SDA_OE, WR_VALID, WP_REVERSIBLE, WP_PERMANENT;
   logic EVENT_OE, SENSOR_READY, MEAS_REQ, scl, sda_m, ack;
   logic [2:0] ADDR_SEL, PTR_SEL;
   logic [7:0] MEM_RD_DATA, b;
   logic [15:0] TEMP_DATA, d, r;
   logic [15:0] shd [1:4];
   logic [FIFO_WIDTH-1:0] WR_DATA;
   logic [FIFO_WIDTH-1:0] got [$];
   logic [FIFO_WIDTH-1:0] exq [$];
   integer seed = 32'hd7233a14;
   int n_errors = 0, samples_checked = 0, meas = 0, n_rd = 0;
   wire sda_w = sda_m & ~SDA_OE;
   tfe_target #(.TIMEOUT_CYCLES(TMO), .WARMUP_CYCLES(WARM), .MFR_ID(MID), .DEV_ID(DID)) u_tfe_target (.CLK(CLK),
      .RST(RST), .SCL_IN(scl),
      .SDA_IN(sda_w), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .ADDR_SEL(ADDR_SEL), .TEMP_DATA(TEMP_DATA),
      .MEM_RD_DATA(MEM_RD_DATA), .WR_VALID(WR_VALID), .WR_READY(WR_READY), .WR_DATA(WR_DATA), .PTR_SEL(PTR_SEL),
      .CONF_WORD(shd[1]), .UPPER_LIMIT(shd[2]), .LOWER_LIMIT(shd[3]), .CRIT_LIMIT(shd[4]),
      .WP_REVERSIBLE(WP_REVERSIBLE), .WP_PERMANENT(WP_PERMANENT), .EVENT_OE(EVENT_OE),
      .SENSOR_READY(SENSOR_READY), .MEAS_REQ(MEAS_REQ));
   tfe_i2c_master u_tfe_i2c_master (.clk(CLK), .scl(scl), .sda(sda_m), .sda_w(sda_w));
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end
   always @(posedge CLK)
   begin
      if (WR_VALID === 1'b1 && WR_READY === 1'b1) got.push_back(WR_DATA);
      if (MEAS_REQ === 1'b1) meas++;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [7:0] rd_exp(input logic [3:0] t);
      return (t == TYPE_MEMORY) ? MEM_RD_DATA : PROT_FILL;
   endfunction
   task automatic wrap_up;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic newsel;
      @(posedge CLK);
      ADDR_SEL <= 3'($random(seed));
      repeat (2) @(posedge CLK);
   endtask
   task automatic sendb(input logic [7:0] v, input logic e);
      u_tfe_i2c_master.wbyte(v, ack);
      check(ack, e);
   endtask
   task automatic twr(input logic [2:0] p, input logic [15:0] v, input logic e);
      newsel();
      u_tfe_i2c_master.start();
      sendb({TYPE_THERMAL, ADDR_SEL, 1'b0}, 1'b1);
      sendb({5'h00, p}, 1'b1);
      sendb(v[15:8], 1'b1);
      sendb(v[7:0], e);
      u_tfe_i2c_master.stop();
   endtask
   task automatic trd(input logic [15:0] v, input logic sp, input logic [2:0] p);
      newsel();
      u_tfe_i2c_master.start();
      if (sp)
      begin
         sendb({TYPE_THERMAL, ADDR_SEL, 1'b0}, 1'b1);
         sendb({5'h00, p}, 1'b1);
         u_tfe_i2c_master.start();
      end
      sendb({TYPE_THERMAL, ADDR_SEL, 1'b1}, 1'b1);
      u_tfe_i2c_master.rbyte(1'b1, r[15:8]);
      u_tfe_i2c_master.rbyte(1'b0, r[7:0]);
      u_tfe_i2c_master.stop();
      n_rd++;
      check(r, v);
   endtask
   task automatic acc(input logic [7:0] a, input logic e);
      u_tfe_i2c_master.start();
      sendb(a, e);
      if (a[0] && e)
      begin
         u_tfe_i2c_master.rbyte(1'b0, b);
         check(b, rd_exp(a[7:4]));
      end
      u_tfe_i2c_master.stop();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      RST = 1'b1;
      WR_READY = 1'b1;
      ADDR_SEL = 3'h0;
      TEMP_DATA = 16'h0000;
      MEM_RD_DATA = 8'h00;
      repeat (4) @(posedge CLK);
      RST <= 1'b0;
      repeat (2) @(posedge CLK);
      check(PTR_SEL, PTR_RESET);
      check(EVENT_OE, 1'b0);
      check(SDA_OUT, 1'b0);
      check(SENSOR_READY, 1'b0);
      for (int p = 1; p < 5; p++) check(shd[p], REG_RESET);
      trd(CAP_VALUE, 1'b0, 3'h0);
      check(SENSOR_READY, 1'b1);
      for (int p = 1; p < 5; p++)
      begin
         d = 16'($random(seed));
         twr(p[2:0], d, 1'b1);
         exq.push_back({1'b0, p[2:0], d});
         check(shd[p], d);
         trd(d, 1'b1, p[2:0]);
         check(PTR_SEL, p);
      end
      trd(d, 1'b0, 3'h0);
      twr(PTR_CAP, 16'h5a5a, 1'b0);
      TEMP_DATA <= 16'($random(seed));
      MEM_RD_DATA <= 8'($random(seed));
      trd(CAP_VALUE, 1'b0, 3'h0);
      trd(MID, 1'b1, PTR_MFR);
      trd(DID, 1'b1, 3'h7);
      trd(TEMP_DATA, 1'b1, PTR_TEMP);
      u_tfe_i2c_master.start();
      repeat (4) u_tfe_i2c_master.bit_io(1'b0, b[0]);
      trd(TEMP_DATA, 1'b0, 3'h0);
      newsel();
      u_tfe_i2c_master.start();
      sendb({TYPE_THERMAL, ADDR_SEL, 1'b0}, 1'b1);
      repeat (TMO + 50) @(posedge CLK);
      sendb(8'h01, 1'b0);
      u_tfe_i2c_master.stop();
      acc({4'h5, ADDR_SEL, 1'b1}, 1'b0);
      acc({TYPE_THERMAL, ~ADDR_SEL, 1'b0}, 1'b0);
      WR_READY <= 1'b0;
      u_tfe_i2c_master.start();
      sendb({TYPE_MEMORY, ADDR_SEL, 1'b0}, 1'b1);
      for (int i = 0; i < 10; i++)
      begin
         b = 8'($random(seed));
         sendb(b, i < 9);
         if (i < 9) exq.push_back({1'b1, 11'h000, b});
      end
      u_tfe_i2c_master.stop();
      WR_READY <= 1'b1;
      acc({TYPE_MEMORY, ADDR_SEL, 1'b1}, 1'b1);
      acc({TYPE_PROTECT, SEL_SET_REV, 1'b0}, 1'b1);
      check(WP_REVERSIBLE, 1'b1);
      acc({TYPE_PROTECT, SEL_SET_REV, 1'b1}, 1'b0);
      acc({TYPE_PROTECT, SEL_CLR_REV, 1'b0}, 1'b1);
      check(WP_REVERSIBLE, 1'b0);
      acc({TYPE_PROTECT, SEL_CLR_REV, 1'b1}, 1'b1);
      ADDR_SEL <= 3'h5;
      repeat (2) @(posedge CLK);
      acc({TYPE_PROTECT, 3'h5, 1'b0}, 1'b1);
      check(WP_PERMANENT, 1'b1);
      acc({TYPE_PROTECT, 3'h5, 1'b1}, 1'b0);
      check(got.size(), exq.size());
      foreach (exq[i]) check(got[i], exq[i]);
      check(meas, n_rd);
      wrap_up();
   end
   initial
   begin
      repeat (30000) @(posedge CLK);
      n_errors++;
      wrap_up();
   end
endmodule // tfe_target_tb_top
`default_nettype wire
